// ===== verilog/timer_pkg.sv
// =============================================================
// timer package
// =============================================================
// holds register indices, field positions, reset values and the
// apb request carrier shared by the timer and its bench.
// assumes a 32-bit apb bus with one byte register per aligned word.
package timer_pkg;

    // =========================================================
    // bus geometry
    // =========================================================
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned IDX_LSB = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h08;
    localparam logic [IDX_W-1:0] IDX_COUNT_HI = 6'h09;
    localparam logic [IDX_W-1:0] IDX_COUNT_LO = 6'h0a;
    localparam logic [IDX_W-1:0] IDX_CMP_HI = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_CMP_LO = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_CAP_HI = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_CAP_LO = 6'h0e;

    // =========================================================
    // status/control field positions
    // =========================================================
    localparam int unsigned BIT_OUT_LEVEL = 0;
    localparam int unsigned BIT_EDGE_SEL = 1;
    localparam int unsigned BIT_OVF_EN = 2;
    localparam int unsigned BIT_CMP_EN = 3;
    localparam int unsigned BIT_CAP_EN = 4;
    localparam int unsigned BIT_OVF_FLAG = 5;
    localparam int unsigned BIT_CMP_FLAG = 6;
    localparam int unsigned BIT_CAP_FLAG = 7;
    localparam int unsigned CTL_W = 5;

    // =========================================================
    // reset and preset values
    // =========================================================
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_PRESET = 16'hfff8;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] CMP_RESET = 16'hffff;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [DATA_W-BYTE_W-1:0] PAD_ZERO = 24'h00_0000;

    // apb request fields that travel together
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

endpackage : timer_pkg

// ===== verilog/sync_two_flop.sv
// =============================================================
// two flip-flop synchroniser
// =============================================================
// brings a level from outside the ref_clk domain into it.
// assumes the source is slow against ref_clk; no pulse stretching.
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    // first stage read only by the second stage
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_r <= '0;
            stable_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule : sync_two_flop

// ===== verilog/timer_capture_compare_unit.sv
// =============================================================
// timer with free running counter, output compare, input capture
// =============================================================
// holds the 16-bit counter, compare and capture registers and the
// control/status byte, reached over apb with one byte per word.
// assumes ref_clk is the e clock; pin direction bits come from the
// port logic on the same clock; the capture pin is asynchronous.
//
// Operation
// - counter high write presets counter to fff8
// - low write loads low, buffered high byte
// - equality sets compare flag, drives level
// - compare level reaches pin when output
// - reset loads compare register all ones
// - no matching on counter or compare-high write cycle and next
// - selected edge copies counter into capture
// - edge select 0 falling, 1 rising
// - status reads all, writes low five
// - overflow flag set at zero, read-cleared
// - compare flag cleared by read, compare write
// - capture flag cleared by read, capture read
// - enables gate flags onto timer request
// - status layout flags high, controls low
// - reset clears whole status register
// - counter steps every clock, reads harmless
// - reset clears the counter
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module timer_capture_compare_unit (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire timer_pkg::apb_req_type apb_req,
    output logic [timer_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin_in,
    input wire logic capture_pin_dir,
    input wire logic compare_pin_dir,
    output logic compare_pin_out,
    output logic compare_pin_oe,
    output logic internal_timer_irq
);

    // =========================================================
    // declarations
    // =========================================================
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic rd_access;
    logic [timer_pkg::IDX_W-1:0] reg_idx;
    logic [timer_pkg::BYTE_W-1:0] wr_byte;
    logic hit_status;
    logic hit_count_hi;
    logic hit_count_lo;
    logic hit_cmp_hi;
    logic hit_cmp_lo;
    logic hit_cap_hi;
    logic hit_cap_lo;
    logic hit_any;
    logic [timer_pkg::BYTE_W-1:0] rd_byte;
    logic [timer_pkg::DATA_W-1:0] prdata_r;

    logic [15:0] counter_r;
    logic [15:0] counter_nxt;
    logic [timer_pkg::BYTE_W-1:0] high_buf_r;
    logic [15:0] compare_r;
    logic [15:0] captured_r;
    logic [timer_pkg::CTL_W-1:0] ctl_r;
    logic [timer_pkg::BYTE_W-1:0] status_byte;

    logic count_write;
    logic inhibit_now;
    logic inhibit_hold_r;
    logic compare_match;
    logic wrap_event;

    logic capture_sync;
    logic capture_prev_r;
    logic capture_edge;

    logic overflow_flag_r;
    logic compare_match_flag_r;
    logic capture_flag_r;
    logic overflow_arm_r;
    logic compare_arm_r;
    logic capture_arm_r;
    logic overflow_clear;
    logic compare_clear;
    logic capture_clear;

    logic level_r;
    logic irq_r;

    // =========================================================
    // apb decode
    // =========================================================
    // phases of a transfer; the slave never adds wait states
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & apb_req.pwrite;
    assign rd_access = access_phase & ~apb_req.pwrite;
    assign reg_idx = apb_req.paddr[timer_pkg::IDX_LSB +: timer_pkg::IDX_W];
    assign wr_byte = apb_req.pwdata[timer_pkg::BYTE_W-1:0];

    // one hit line per byte register
    assign hit_status = (reg_idx == timer_pkg::IDX_STATUS);
    assign hit_count_hi = (reg_idx == timer_pkg::IDX_COUNT_HI);
    assign hit_count_lo = (reg_idx == timer_pkg::IDX_COUNT_LO);
    assign hit_cmp_hi = (reg_idx == timer_pkg::IDX_CMP_HI);
    assign hit_cmp_lo = (reg_idx == timer_pkg::IDX_CMP_LO);
    assign hit_cap_hi = (reg_idx == timer_pkg::IDX_CAP_HI);
    assign hit_cap_lo = (reg_idx == timer_pkg::IDX_CAP_LO);
    assign hit_any = hit_status | hit_count_hi | hit_count_lo | hit_cmp_hi
        | hit_cmp_lo | hit_cap_hi | hit_cap_lo;

    // answer in the first access cycle; unmapped words flag an error
    assign pready = access_phase;
    assign pslverr = access_phase & ~hit_any;

    assign status_byte = {capture_flag_r, compare_match_flag_r, overflow_flag_r, ctl_r};

    // read mux, sampled at the setup edge
    always_comb
    begin
        rd_byte = timer_pkg::BYTE_RESET;
        if (hit_status)
        begin
            rd_byte = status_byte;
        end
        else if (hit_count_hi)
        begin
            rd_byte = counter_r[15:8];
        end
        else if (hit_count_lo)
        begin
            rd_byte = counter_r[7:0];
        end
        else if (hit_cmp_hi)
        begin
            rd_byte = compare_r[15:8];
        end
        else if (hit_cmp_lo)
        begin
            rd_byte = compare_r[7:0];
        end
        else if (hit_cap_hi)
        begin
            rd_byte = captured_r[15:8];
        end
        else if (hit_cap_lo)
        begin
            rd_byte = captured_r[7:0];
        end
    end

    // read data register, loaded during the setup cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prdata_r <= timer_pkg::WORD_RESET;
        end
        else if (setup_phase & ~apb_req.pwrite)
        begin
            prdata_r <= {timer_pkg::PAD_ZERO, rd_byte};
        end
    end

    assign prdata = prdata_r;

    // =========================================================
    // control bits
    // =========================================================
    // only low five bits writable
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctl_r <= timer_pkg::CTL_RESET;
        end
        else if (wr_access & hit_status)
        begin
            ctl_r <= wr_byte[timer_pkg::CTL_W-1:0];
        end
    end

    // =========================================================
    // free running counter
    // =========================================================
    assign count_write = wr_access & (hit_count_hi | hit_count_lo);

    // next count value; writes override the step
    always_comb
    begin
        counter_nxt = counter_r + timer_pkg::COUNT_STEP;
        if (wr_access & hit_count_hi)
        begin
            counter_nxt = timer_pkg::COUNT_PRESET;
        end
        else if (wr_access & hit_count_lo)
        begin
            counter_nxt = {high_buf_r, wr_byte};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            counter_r <= timer_pkg::COUNT_RESET;
        end
        else
        begin
            counter_r <= counter_nxt;
        end
    end

    // keep high byte for low write
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            high_buf_r <= timer_pkg::BYTE_RESET;
        end
        else if (wr_access & hit_count_hi)
        begin
            high_buf_r <= wr_byte;
        end
    end

    assign wrap_event = (counter_r == timer_pkg::COUNT_MAX) & ~count_write;

    // =========================================================
    // output compare
    // =========================================================
    // compare reset all ones
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            compare_r <= timer_pkg::CMP_RESET;
        end
        else if (wr_access & hit_cmp_hi)
        begin
            compare_r[15:8] <= wr_byte;
        end
        else if (wr_access & hit_cmp_lo)
        begin
            compare_r[7:0] <= wr_byte;
        end
    end

    assign inhibit_now = count_write | (wr_access & hit_cmp_hi);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            inhibit_hold_r <= 1'b0;
        end
        else
        begin
            inhibit_hold_r <= inhibit_now;
        end
    end

    assign compare_match = (counter_r == compare_r) & ~inhibit_now & ~inhibit_hold_r;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            level_r <= 1'b0;
        end
        else if (compare_match)
        begin
            level_r <= ctl_r[timer_pkg::BIT_OUT_LEVEL];
        end
    end

    assign compare_pin_out = level_r;
    assign compare_pin_oe = compare_pin_dir;

    // =========================================================
    // input capture
    // =========================================================
    // pin passes two flops first
    sync_two_flop #(
        .WIDTH(1)
    ) capture_sync_inst (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(capture_pin_in),
        .sync_out(capture_sync)
    );

    // previous synchronised level for edge detection
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            capture_prev_r <= 1'b0;
        end
        else
        begin
            capture_prev_r <= capture_sync;
        end
    end

    // pin gated in only as input
    assign capture_edge = ~capture_pin_dir
        & (ctl_r[timer_pkg::BIT_EDGE_SEL] ? (capture_sync & ~capture_prev_r)
                                          : (~capture_sync & capture_prev_r));

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            captured_r <= timer_pkg::CAP_RESET;
        end
        else if (capture_edge)
        begin
            captured_r <= counter_r;
        end
    end

    // =========================================================
    // flag clearing sequences
    // =========================================================
    // a status read that returned a set flag arms its clear
    assign overflow_clear = overflow_arm_r & rd_access & hit_count_hi;
    assign compare_clear = compare_arm_r & wr_access & (hit_cmp_hi | hit_cmp_lo);
    assign capture_clear = capture_arm_r & rd_access & hit_cap_hi;

    // arm bits follow the value returned by the status read
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            overflow_arm_r <= 1'b0;
            compare_arm_r <= 1'b0;
            capture_arm_r <= 1'b0;
        end
        else if (rd_access & hit_status)
        begin
            overflow_arm_r <= prdata_r[timer_pkg::BIT_OVF_FLAG];
            compare_arm_r <= prdata_r[timer_pkg::BIT_CMP_FLAG];
            capture_arm_r <= prdata_r[timer_pkg::BIT_CAP_FLAG];
        end
        else
        begin
            overflow_arm_r <= overflow_arm_r & ~overflow_clear;
            compare_arm_r <= compare_arm_r & ~compare_clear;
            capture_arm_r <= capture_arm_r & ~capture_clear;
        end
    end

    // =========================================================
    // status flags, set wins over clear
    // =========================================================
    // overflow set and clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            overflow_flag_r <= 1'b0;
        end
        else
        begin
            overflow_flag_r <= wrap_event | (overflow_flag_r & ~overflow_clear);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            compare_match_flag_r <= 1'b0;
        end
        else
        begin
            compare_match_flag_r <= compare_match | (compare_match_flag_r & ~compare_clear);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            capture_flag_r <= 1'b0;
        end
        else
        begin
            capture_flag_r <= capture_edge | (capture_flag_r & ~capture_clear);
        end
    end

    // =========================================================
    // timer request
    // =========================================================
    // enables gate flags
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= (overflow_flag_r & ctl_r[timer_pkg::BIT_OVF_EN])
                | (compare_match_flag_r & ctl_r[timer_pkg::BIT_CMP_EN])
                | (capture_flag_r & ctl_r[timer_pkg::BIT_CAP_EN]);
        end
    end

    assign internal_timer_irq = irq_r;

endmodule : timer_capture_compare_unit

// ===== tb/timer_checker.sv
// =============================================================
// concurrent checks on the timer apb port, compare pin and request
// assumes it is bound to the timer top module and sees only its ports
`timescale 1ns/1ps
module timer_checker (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire timer_pkg::apb_req_type apb_req,
    input wire logic [timer_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_pin_in,
    input wire logic capture_pin_dir,
    input wire logic compare_pin_dir,
    input wire logic compare_pin_out,
    input wire logic compare_pin_oe,
    input wire logic internal_timer_irq
);
    // =========================================================
    // helpers
    // =========================================================
    logic mapped;
    logic rd_setup;
    // word index decode and read setup cycle
    assign mapped = (apb_req.paddr[7:2] >= 6'h08) && (apb_req.paddr[7:2] <= 6'h0e);
    assign rd_setup = psel && !penable && !apb_req.pwrite;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // =========================================================
    // assertions
    // =========================================================
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready differs from the access phase");
    a_oe_follows_dir: assert property (compare_pin_oe == compare_pin_dir)
        else $error("compare pin enable differs from its direction bit");
    a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on an unmapped access");
    a_no_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on a mapped access");
    a_upper_bits_zero: assert property (psel && penable |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the byte is not zero");
    a_unmapped_reads_zero: assert property (psel && penable && !apb_req.pwrite && !mapped
        |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_read_data_holds: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data changed outside a read setup");
    a_irq_reset_low: assert property ($past(srst) |-> !internal_timer_irq)
        else $error("request high right after reset");
    a_level_reset_low: assert property ($past(srst) |-> !compare_pin_out)
        else $error("compare level high right after reset");
    // main scenarios
    c_write: cover property (psel && penable && apb_req.pwrite);
    c_read_setup: cover property (rd_setup);
    c_unmapped: cover property (pslverr);
    c_irq: cover property (internal_timer_irq);
endmodule : timer_checker

bind timer_capture_compare_unit timer_checker u_checker (.ref_clk(ref_clk), .srst(srst),
    .psel(psel), .penable(penable), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin_in(capture_pin_in), .capture_pin_dir(capture_pin_dir),
    .compare_pin_dir(compare_pin_dir), .compare_pin_out(compare_pin_out),
    .compare_pin_oe(compare_pin_oe), .internal_timer_irq(internal_timer_irq));

// ===== tb/capture_source.sv
// =============================================================
// model of the external source that drives the capture pin
// assumes fire is a one cycle request from the bench on ref_clk
`timescale 1ns/1ps
module capture_source #(
    parameter int HOLD = 3
) (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic idle_level,
    output logic pin
);
    int left = 0;
    // =========================================================
    // pulse timing
    // =========================================================
    // pulse held several clocks
    always @(posedge ref_clk)
    begin
        if (fire)
            left <= HOLD;
        else if (left > 0)
            left <= left - 1;
    end
    // pin rests at the idle level outside a pulse
    assign pin = (left > 0) ? !idle_level : idle_level;
endmodule : capture_source

// ===== tb/testbench.sv
// =============================================================
// self-checking bench: apb master tasks, counter model, capture source
// assumes a zero wait apb slave with one byte register per word
`timescale 1ns/1ps
`define CHK(nm, x, y) begin n_tests++; if ((y) !== (x)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, x, y); end end
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    timer_pkg::apb_req_type apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, capture_pin_in, compare_pin_out, compare_pin_oe, internal_timer_irq;
    // capture pin kept as input except in the gating check
    logic capture_pin_dir = 1'b0;
    // compare pin kept as output except in the enable check
    logic compare_pin_dir = 1'b1;
    logic fire = 1'b0;
    logic idle_level = 1'b1;
    int cyc = 0;
    int bad_count = 0;
    int n_tests = 0;
    logic [15:0] mval = 16'h0000;
    int mcyc = 0;
    logic [7:0] hbuf = 8'h00;

    // =========================================================
    // clock, design and partner
    // =========================================================
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    timer_capture_compare_unit u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_pin_in(capture_pin_in), .capture_pin_dir(capture_pin_dir),
        .compare_pin_dir(compare_pin_dir), .compare_pin_out(compare_pin_out),
        .compare_pin_oe(compare_pin_oe), .internal_timer_irq(internal_timer_irq));
    capture_source u_src (.ref_clk(ref_clk), .fire(fire), .idle_level(idle_level),
        .pin(capture_pin_in));

    // =========================================================
    // model and bus tasks
    // =========================================================
    // counter value seen by a read whose setup edge had cycle sc
    function automatic logic [15:0] cnt_at(input int sc);
        return mval + 16'(sc - mcyc - 1);
    endfunction : cnt_at

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // one apb transfer; setup and access edge cycles returned
    task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] d,
        output logic [7:0] g, output int sc, output int ac);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        apb_req <= {{idx, 2'h0}, wr, {24'h00_0000, d}};
        @(posedge ref_clk);
        sc = cyc;
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            bad_count++;
            end_of_test();
        end
        ac = cyc;
        g = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write, keeping the counter model in step
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] g;
        int sc;
        int ac;
        apb(idx, 1'b1, d, g, sc, ac);
        if (idx == timer_pkg::IDX_COUNT_HI)
        begin
            mval = 16'hfff8;
            mcyc = ac;
            hbuf = d;
        end
        else if (idx == timer_pkg::IDX_COUNT_LO)
        begin
            mval = {hbuf, d};
            mcyc = ac;
        end
    endtask : wr

    task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] g;
        int sc;
        int ac;
        apb(idx, 1'b0, 8'h00, g, sc, ac);
        `CHK(nm, e, g)
    endtask : rchk

    task automatic rcnt(input logic hi);
        logic [7:0] g;
        logic [15:0] e;
        int sc;
        int ac;
        apb(hi ? timer_pkg::IDX_COUNT_HI : timer_pkg::IDX_COUNT_LO, 1'b0, 8'h00, g, sc, ac);
        e = cnt_at(sc);
        `CHK("counter", (hi ? e[15:8] : e[7:0]), g)
    endtask : rcnt

    // =========================================================
    // scenarios
    // =========================================================
    initial
    begin
        logic [15:0] ce;
        int p;
        void'($urandom(32'h3a9ce9b8));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        mcyc = cyc;
        // reset values and status access
        rcnt(1'b1);
        rcnt(1'b0);
        rchk("status", timer_pkg::IDX_STATUS, 8'h00);
        rchk("cmp hi", timer_pkg::IDX_CMP_HI, 8'hff);
        rchk("cmp lo", timer_pkg::IDX_CMP_LO, 8'hff);
        rchk("unmapped", 6'h20, 8'h00);
        wr(timer_pkg::IDX_STATUS, 8'hff);
        rchk("status", timer_pkg::IDX_STATUS, 8'h1f);
        // preset, wrap, compare at ffff, flag clearing
        wr(timer_pkg::IDX_STATUS, 8'h05);
        wr(timer_pkg::IDX_COUNT_HI, 8'($urandom));
        rcnt(1'b1);
        rcnt(1'b0);
        repeat (12) @(posedge ref_clk);
        rchk("status", timer_pkg::IDX_STATUS, 8'h65);
        `CHK("level pin", 1'b1, compare_pin_out)
        `CHK("pin enable", 1'b1, compare_pin_oe)
        `CHK("irq", 1'b1, internal_timer_irq)
        // pin turned to input: the level must stop driving it
        compare_pin_dir <= 1'b0;
        @(posedge ref_clk);
        `CHK("pin enable", 1'b0, compare_pin_oe)
        compare_pin_dir <= 1'b1;
        rcnt(1'b1);
        repeat (2) @(posedge ref_clk);
        `CHK("irq", 1'b0, internal_timer_irq)
        wr(timer_pkg::IDX_CMP_HI, 8'h12);
        wr(timer_pkg::IDX_CMP_LO, 8'h34);
        rchk("status", timer_pkg::IDX_STATUS, 8'h05);
        // full counter load
        wr(timer_pkg::IDX_COUNT_HI, 8'h20 + 8'($urandom % 64));
        wr(timer_pkg::IDX_COUNT_LO, 8'($urandom));
        rcnt(1'b1);
        rcnt(1'b0);
        // inhibited match, then a real match at level 0
        wr(timer_pkg::IDX_STATUS, 8'h08);
        wr(timer_pkg::IDX_CMP_HI, 8'h70);
        wr(timer_pkg::IDX_CMP_LO, 8'h00);
        wr(timer_pkg::IDX_COUNT_HI, 8'h70);
        wr(timer_pkg::IDX_COUNT_LO, 8'h00);
        rchk("status", timer_pkg::IDX_STATUS, 8'h08);
        wr(timer_pkg::IDX_CMP_LO, 8'h40);
        repeat (80) @(posedge ref_clk);
        rchk("status", timer_pkg::IDX_STATUS, 8'h48);
        `CHK("level pin", 1'b0, compare_pin_out)
        `CHK("irq", 1'b1, internal_timer_irq)
        wr(timer_pkg::IDX_CMP_LO, 8'h40);
        rchk("status", timer_pkg::IDX_STATUS, 8'h08);
        // an edge on a pin set as output must not capture
        capture_pin_dir <= 1'b1;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rchk("status", timer_pkg::IDX_STATUS, 8'h08);
        capture_pin_dir <= 1'b0;
        // capture on each edge select
        for (int es = 0; es < 2; es++)
        begin
            wr(timer_pkg::IDX_STATUS, 8'h10 | 8'(es << 1));
            idle_level <= (es == 0);
            repeat (6) @(posedge ref_clk);
            fire <= 1'b1;
            p = cyc;
            @(posedge ref_clk);
            fire <= 1'b0;
            repeat (10) @(posedge ref_clk);
            ce = cnt_at(p + 4);
            rchk("status", timer_pkg::IDX_STATUS, 8'h90 | 8'(es << 1));
            `CHK("irq", 1'b1, internal_timer_irq)
            rchk("cap hi", timer_pkg::IDX_CAP_HI, ce[15:8]);
            rchk("cap lo", timer_pkg::IDX_CAP_LO, ce[7:0]);
            rchk("status", timer_pkg::IDX_STATUS, 8'h10 | 8'(es << 1));
        end
        end_of_test();
    end
endmodule : testbench
